// [rtl/rail_sequence_timestamp_log.sv]
// Functional notes
// - upper stamp byte at even pair address
// - lower stamp byte at next address
// - capture running timer on triggered sequence
// - up sequence: capture on undervoltage crossing
// - down sequence: capture on off-threshold crossing
// - timer advances once per tick period
`timescale 1ns/1ps
`default_nettype none
module rail_sequence_timestamp_log
   import seq_stamp_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES
) (
   input  wire logic              core_clk_in,
   input  wire logic              rstn_in,
   input  wire logic              power_state_input_in,
   input  wire logic              low_power_input_in,
   input  wire logic [NUM_CH-1:0] above_uv_in,
   input  wire logic [NUM_CH-1:0] above_off_in,
   input  wire logic [7:0]        rd_addr_in,
   output logic      [7:0]        rd_data_out,
   output logic      [NUM_CH-1:0] captured_out
);
   logic [1:0]        act_sync_q;
   logic [1:0]        lp_sync_q;
   logic              act_prev_q;
   logic              lp_prev_q;
   logic [NUM_CH-1:0] uv_s1_q;
   logic [NUM_CH-1:0] uv_s2_q;
   logic [NUM_CH-1:0] off_s1_q;
   logic [NUM_CH-1:0] off_s2_q;
   logic [NUM_CH-1:0] uv_prev_q;
   logic [NUM_CH-1:0] off_prev_q;
   seq_state_type     state_q;
   logic [STAMP_W-1:0] timer_q;
   logic [STAMP_W-1:0] stamp_q [NUM_CH];
   logic [NUM_CH-1:0] done_q;
   logic              start_up;
   logic              start_down;
   logic              start;
   logic              tick;
   logic [NUM_CH-1:0] hit;
   logic [7:0]        rd_data_d;

   // two-flop synchronisers for pin inputs
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         act_sync_q <= '0;
         lp_sync_q  <= '0;
         uv_s1_q    <= '0;
         uv_s2_q    <= '0;
         off_s1_q   <= '0;
         off_s2_q   <= '0;
      end else begin
         act_sync_q <= {act_sync_q[0], power_state_input_in};
         lp_sync_q  <= {lp_sync_q[0], low_power_input_in};
         uv_s1_q    <= above_uv_in;
         uv_s2_q    <= uv_s1_q;
         off_s1_q   <= above_off_in;
         off_s2_q   <= off_s1_q;
      end
   end

   // edge history, read only from the second synchroniser stage
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         act_prev_q <= 1'b0;
         lp_prev_q  <= 1'b0;
         uv_prev_q  <= '0;
         off_prev_q <= '1;
      end else begin
         act_prev_q <= act_sync_q[1];
         lp_prev_q  <= lp_sync_q[1];
         uv_prev_q  <= uv_s2_q;
         off_prev_q <= off_s2_q;
      end
   end

   // 0->1 on either control starts an up sequence, 1->0 a down one
   assign start_up   = (act_sync_q[1] && !act_prev_q)
                     || (lp_sync_q[1] && !lp_prev_q);
   assign start_down = (!act_sync_q[1] && act_prev_q)
                     || (!lp_sync_q[1] && lp_prev_q);
   assign start      = start_up || start_down;

   // a down edge wins if both happen at once, the rail is going away
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_q <= SEQ_IDLE;
      end else if (start_down) begin
         state_q <= SEQ_DOWN;
      end else if (start_up) begin
         state_q <= SEQ_UP;
      end
   end

   seq_tick_gen #(
      .TICK_LEN    (TICK_LEN)
   ) u_tick (
      .core_clk_in (core_clk_in),
      .rstn_in     (rstn_in),
      .restart_in  (start),
      .tick_out    (tick)
   );

   // sequence timer; saturates rather than wrap so late stamps stay ordered
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         timer_q <= '0;
      end else if (start) begin
         timer_q <= '0;
      end else if (tick && state_q != SEQ_IDLE && timer_q != '1) begin
         timer_q <= timer_q + 1'b1;
      end
   end

   // threshold crossing per channel, by sequence direction
   always_comb begin
      hit = '0;
      unique case (state_q)
         SEQ_UP:   hit = uv_s2_q & ~uv_prev_q;
         SEQ_DOWN: hit = ~off_s2_q & off_prev_q;
         SEQ_IDLE: hit = '0;
      endcase
   end

   // capture once per sequence; value held until next sequence
   // a start beats a same-cycle hit: that crossing ends the old sequence
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         done_q <= '0;
         for (int i = 0; i < NUM_CH; i++) begin
            stamp_q[i] <= STAMP_RESET;
         end
      end else if (start) begin
         done_q <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (hit[i] && !done_q[i]) begin
               stamp_q[i] <= timer_q;
               done_q[i]  <= 1'b1;
            end
         end
      end
   end

   assign captured_out = done_q;

   // byte halves of a stamp, shared by the read mux and its checks
   function automatic logic [7:0] hi_byte(input logic [STAMP_W-1:0] s);
      return s[STAMP_W-1:STAMP_W/2];
   endfunction

   function automatic logic [7:0] lo_byte(input logic [STAMP_W-1:0] s);
      return s[STAMP_W/2-1:0];
   endfunction

   // read mux: even address high byte, odd address low byte
   always_comb begin
      rd_data_d = READ_UNMAPPED;
      unique case (rd_addr_in)
         ADDR_STAMP_HIGH_CH2: rd_data_d = hi_byte(stamp_q[0]);
         ADDR_STAMP_LOW_CH2:  rd_data_d = lo_byte(stamp_q[0]);
         ADDR_STAMP_HIGH_CH3: rd_data_d = hi_byte(stamp_q[1]);
         ADDR_STAMP_LOW_CH3:  rd_data_d = lo_byte(stamp_q[1]);
         ADDR_STAMP_HIGH_CH4: rd_data_d = hi_byte(stamp_q[2]);
         ADDR_STAMP_LOW_CH4:  rd_data_d = lo_byte(stamp_q[2]);
         default:             rd_data_d = READ_UNMAPPED;
      endcase
   end

   // registered read data; no latch between the bytes, so a read that
   // straddles a capture may pair an old high byte with a new low byte
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rd_data_out <= READ_UNMAPPED;
      end else begin
         rd_data_out <= rd_data_d;
      end
   end

   // timer cleared right after a start
   a_timer_restart: assert property (@(posedge core_clk_in)
      disable iff (!rstn_in) start |=> timer_q == '0)
      else $error("timer not cleared on start");

   // outside a start, timer moves only on a tick
   a_timer_tick_only: assert property (@(posedge core_clk_in)
      disable iff (!rstn_in) (!start && !tick) |=> $stable(timer_q))
      else $error("timer moved without tick");

   // a hit captures current timer value
   a_capture_value: assert property (@(posedge core_clk_in)
      disable iff (!rstn_in) (!start && hit[0] && !done_q[0])
      |=> stamp_q[0] == $past(timer_q) && done_q[0])
      else $error("channel stamp not captured");

   // a done channel keeps its stamp
   a_stamp_held: assert property (@(posedge core_clk_in)
      disable iff (!rstn_in) (done_q[1] && !start) |=> $stable(stamp_q[1]))
      else $error("stamp changed after capture");

   // a captured flag stays up until the next start
   a_flag_held: assert property (@(posedge core_clk_in)
      disable iff (!rstn_in) (done_q[2] && !start) |=> done_q[2])
      else $error("captured flag dropped inside a sequence");

   // a start empties every captured flag
   a_flags_clear: assert property (@(posedge core_clk_in)
      disable iff (!rstn_in) start |=> captured_out == '0)
      else $error("captured flags not cleared on start");

   // nothing is captured while no sequence runs
   a_idle_no_capture: assert property (@(posedge core_clk_in)
      disable iff (!rstn_in) (state_q == SEQ_IDLE && !start)
      |=> $stable(done_q))
      else $error("capture while idle");

   // up sequence after rising control edge
   a_up_seq: assert property (@(posedge core_clk_in)
      disable iff (!rstn_in) (start_up && !start_down) |=> state_q == SEQ_UP)
      else $error("up sequence not entered");

   // down sequence after falling control edge
   a_down_seq: assert property (@(posedge core_clk_in)
      disable iff (!rstn_in) start_down |=> state_q == SEQ_DOWN)
      else $error("down sequence not entered");

   // high byte readback
   a_read_high: assert property (@(posedge core_clk_in)
      disable iff (!rstn_in) rd_addr_in == ADDR_STAMP_HIGH_CH3
      |=> rd_data_out == $past(hi_byte(stamp_q[1])))
      else $error("high byte readback wrong");

   // low byte readback
   a_read_low: assert property (@(posedge core_clk_in)
      disable iff (!rstn_in) rd_addr_in == ADDR_STAMP_LOW_CH4
      |=> rd_data_out == $past(lo_byte(stamp_q[2])))
      else $error("low byte readback wrong");
endmodule
`default_nettype wire

// [rtl/seq_stamp_pkg.sv]
package seq_stamp_pkg;
   // register byte addresses of the stamp pairs for channels 2 to 4
   localparam logic [7:0] ADDR_STAMP_HIGH_CH2 = 8'h92;
   localparam logic [7:0] ADDR_STAMP_LOW_CH2  = 8'h93;
   localparam logic [7:0] ADDR_STAMP_HIGH_CH3 = 8'h94;
   localparam logic [7:0] ADDR_STAMP_LOW_CH3  = 8'h95;
   localparam logic [7:0] ADDR_STAMP_HIGH_CH4 = 8'h96;
   localparam logic [7:0] ADDR_STAMP_LOW_CH4  = 8'h97;
   localparam logic [7:0] ADDR_FIRST          = ADDR_STAMP_HIGH_CH2;
   localparam int         NUM_CH              = 3;
   localparam int         STAMP_W             = 16;
   localparam logic [15:0] STAMP_RESET        = 16'h0000;
   localparam logic [7:0]  READ_UNMAPPED      = 8'h00;
   // tick timing at a 100 MHz core clock
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_US       = 50;
   localparam int TICK_CYCLES   = (TICK_US * 1000) / CLK_PERIOD_NS;
   localparam int TICK_W        = 13;
   // sequence direction
   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_UP   = 3'b010,
      SEQ_DOWN = 3'b100
   } seq_state_type;
endpackage

// [rtl/seq_tick_gen.sv]
`timescale 1ns/1ps
`default_nettype none
// one-cycle pulse every tick period; restarts with the sequence
module seq_tick_gen
   import seq_stamp_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES
) (
   input  wire logic core_clk_in,
   input  wire logic rstn_in,
   input  wire logic restart_in,
   output logic      tick_out
);
   localparam logic [TICK_W-1:0] LAST = TICK_W'(TICK_LEN - 1);
   logic [TICK_W-1:0] cnt_q;

   // prescaler from core clock down to the timestamp tick
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cnt_q <= '0;
      end else if (restart_in || cnt_q == LAST) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   assign tick_out = (cnt_q == LAST) && !restart_in;
endmodule
`default_nettype wire

// [verif/seq_host.sv]
`timescale 1ns/1ps
`default_nettype none
// host side of the register read path: presents an address and catches
// the byte one cycle after the block answers
module seq_host (
   input  wire logic       core_clk_in,
   input  wire logic       rstn_in,
   input  wire logic [7:0] want_addr_in,
   input  wire logic [7:0] rd_data_in,
   output logic      [7:0] rd_addr_out,
   output logic      [7:0] data_seen_out
);
   // address held steady every cycle; the block answers one edge later
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rd_addr_out   <= 8'h00;
         data_seen_out <= 8'h00;
      end else begin
         rd_addr_out   <= want_addr_in;
         data_seen_out <= rd_data_in;
      end
   end
endmodule
`default_nettype wire

// [verif/rail_sequence_timestamp_log_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module rail_sequence_timestamp_log_tb_top;
   import seq_stamp_pkg::*;
   localparam int TL = 8;   // shortened tick so sequences stay short
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        ps = 1'b0;
   logic        lp = 1'b0;
   logic [2:0]  uv = 3'b000;
   logic [2:0]  off = 3'b000;
   logic [7:0]  want = 8'h00;
   logic [7:0]  rd_addr, rd_data, seen, seed = 8'h3A;
   logic [2:0]  captured;
   logic [15:0] exp_s [3] = '{default: 16'h0000};
   int          errors = 0;
   int          checks_done = 0;
   rail_sequence_timestamp_log #(.TICK_LEN(TL)) uut (.core_clk_in(clk),
      .rstn_in(rstn), .power_state_input_in(ps), .low_power_input_in(lp),
      .above_uv_in(uv), .above_off_in(off), .rd_addr_in(rd_addr),
      .rd_data_out(rd_data), .captured_out(captured));
   seq_host host (.core_clk_in(clk), .rstn_in(rstn), .want_addr_in(want),
      .rd_data_in(rd_data), .rd_addr_out(rd_addr), .data_seen_out(seen));
   initial begin
      forever #5 clk = ~clk;
   end
   function automatic logic [7:0] rnd();
      seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
      return seed;
   endfunction
   // stamp a channel should hold when it crosses cyc cycles after the pin
   function automatic logic [15:0] exp_stamp(input int cyc);
      return 16'(cyc / TL);
   endfunction
   function automatic logic [7:0] exp_read(input logic [7:0] a);
      if (a < ADDR_STAMP_HIGH_CH2 || a > ADDR_STAMP_LOW_CH4) begin
         return READ_UNMAPPED;
      end
      return a[0] ? exp_s[(a - ADDR_FIRST) >> 1][7:0]
                  : exp_s[(a - ADDR_FIRST) >> 1][15:8];
   endfunction
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      want <= a;
      repeat (3) @(posedge clk);
      #1 d = seen;
   endtask
   // read every stamp pair plus the unmapped 0x91 and 0x98 and two random addresses
   task automatic check_regs();
      logic [7:0] h, l, a;
      for (int i = 0; i < NUM_CH; i++) begin
         rd(ADDR_FIRST + 8'(2 * i), h);
         rd(ADDR_FIRST + 8'(2 * i + 1), l);
         `CHK("stamp", exp_s[i], {h, l})
      end
      for (int j = 0; j < 4; j++) begin
         a = (j == 0) ? 8'h91 : (j == 1) ? 8'h98 : rnd();
         rd(a, h);
         `CHK("byte", exp_read(a), h)
      end
   endtask
   // mode bit0: down sequence, bit1: low-power pin instead of power-state,
   // bit2: power-state rises as low-power falls inside a running up sequence
   task automatic run_seq(input int mode);
      int t, k;
      logic up;
      up = !mode[0];
      t = 0;
      k = 0;
      @(posedge clk);
      if (mode[2]) begin
         lp  <= 1'b1;
         off <= 3'b111;
         repeat (2 * TL) @(posedge clk);
      end
      if (mode[2]) begin
         ps <= 1'b1; // clash of both edges: the falling one must win
         lp <= 1'b0;
      end else if (mode[1]) begin
         lp <= up;
      end else begin
         ps <= up;
      end
      if (up) off <= 3'b111; else uv <= 3'b000;
      for (int i = 0; i < 3; i++) begin
         k = k + 1 + rnd() % 4; // crossings at least one tick apart
         repeat (TL * k + TL / 2 - t) @(posedge clk);
         t = TL * k + TL / 2;
         if (i == 0) `CHK("flags clear", 3'b000, captured)
         if (up) uv[i] <= 1'b1; else off[i] <= 1'b0;
         exp_s[i] = exp_stamp(t);
      end
      // a second crossing in the same sequence must leave the stamps alone
      repeat (2 * TL) @(posedge clk);
      if (up) uv <= 3'b000; else off <= 3'b111;
      repeat (4) @(posedge clk);
      if (up) uv <= 3'b111; else off <= 3'b000;
      repeat (2 * TL) @(posedge clk);
      `CHK("captured", 3'b111, captured)
      check_regs();
      $display("test sequence mode %0d done", mode);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // watchdog: the whole run needs about a thousand cycles, the limit is 20000
   initial begin
      #200000;
      errors++;
      end_sim();
   end
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      // crossings with no sequence running are ignored
      repeat (2) @(posedge clk);
      uv <= 3'b101;
      repeat (6) @(posedge clk);
      uv <= 3'b000;
      repeat (6) @(posedge clk);
      `CHK("idle flags", 3'b000, captured)
      check_regs();
      $display("test idle done");
      for (int m = 0; m < 4; m++) run_seq(m);
      run_seq(5);
      // a reset in mid-run must wipe every stamp and flag
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      exp_s = '{default: 16'h0000};
      repeat (2) @(posedge clk);
      `CHK("reset flags", 3'b000, captured)
      check_regs();
      $display("test reset done");
      end_sim();
   end
endmodule
`default_nettype wire
